//--- axis_feedback_position_counter.sv
// Five-axis feedback counter with drive polarity, jog sense and register bus.
//
// Notes on behaviour
// - Per axis, a setting reverses the counting direction for a phase order.
// - Per axis, a setting inverts the velocity command sent to the drive.
// - Per axis, a setting chooses which direction each jog key produces.
// - Edge multiplication is x4 when the setting is 0, x2 when 1.
// - A signal-type setting selects sine-wave or square-wave feedback.
// - Sine-wave feedback always adds a further x5 factor.
// - Square-wave codes 1, 2, 5, 10 give that many base units per count.
// - Sine-wave, fine setting 1: codes 1, 2, 5, 10 likewise.
// - Sine-wave, fine setting 0: code 5 gives 1, code 10 gives 2; others invalid.
// - Units setting 0 means mm or degrees, 1 means inches.
// - W and V axes may be set linear or rotary.
// - A flag marks the feedback as a 1024 or 2048 line binary encoder.
// - Equivalence 0 scales binary counts as 1250 or 2500 per turn.
// - Equivalence 1 scales binary counts as 1000 or 2000 per turn.
`timescale 1ns/1ps
`default_nettype none
module axis_feedback_position_counter #(
    parameter int AXES = axis_fb_pkg::NUM_AXES   // Number of axes.
) (
    input  wire logic                           clk_i,         // Clock.
    input  wire logic                           reset_i,       // Sync reset.
    // Avalon-MM slave.
    input  wire logic [axis_fb_pkg::ADDR_W-1:0] address_i,     // Byte address.
    input  wire logic                           read_i,        // Read strobe.
    input  wire logic                           write_i,       // Write strobe.
    input  wire logic [axis_fb_pkg::DATA_W-1:0] writedata_i,   // Write data.
    input  wire logic [3:0]                     byteenable_i,  // Byte lanes.
    output logic      [axis_fb_pkg::DATA_W-1:0] readdata_o,    // Read data.
    output logic                                waitrequest_o, // Stall.
    // Feedback pins, one pair per axis.
    input  wire axis_fb_pkg::quad_pins_t [AXES-1:0] quad_i,    // Channels.
    // Servo command path.
    input  wire logic [AXES-1:0][axis_fb_pkg::CMD_W-1:0] vel_cmd_i, // Command.
    output logic      [AXES-1:0][axis_fb_pkg::CMD_W-1:0] drive_cmd_o, // Drive.
    // Operator panel jog keys.
    input  wire logic [AXES-1:0]                jog_plus_key_i,  // Key +.
    input  wire logic [AXES-1:0]                jog_minus_key_i, // Key -.
    output logic      [AXES-1:0]                jog_fwd_o,       // Move +.
    output logic      [AXES-1:0]                jog_rev_o        // Move -.
);
    import axis_fb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        axis_cfg_t [AXES-1:0]              cfg;
        logic [AXES-1:0][POS_W-1:0]        pos;
        logic [AXES-1:0]                   phase_err;
        logic [AXES-1:0][CMD_W-1:0]        drive;
        logic [AXES-1:0]                   jog_fwd;
        logic [AXES-1:0]                   jog_rev;
        logic                              ack;
        logic [DATA_W-1:0]                 rdata;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [AXES-1:0]              dec_step;
    logic [AXES-1:0]              dec_up;
    logic [AXES-1:0]              dec_bad;
    logic [AXES-1:0][POS_W-1:0]   scaled;
    res_step_t [AXES-1:0]         res;

    ////////////////////////////////////////////////////////////////////////////
    // Per-axis decoder and scaler.
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            assign res[g] = res_step(s_q.cfg[g]);

            quad_decoder u_dec (
                .clk_i     (clk_i),
                .reset_i   (reset_i),
                .pins_i    (quad_i[g]),
                .edge_x2_i (s_q.cfg[g].edge_x2),
                .step_o    (dec_step[g]),
                .up_o      (dec_up[g]),
                .bad_o     (dec_bad[g])
            );

            position_scaler u_scl (
                .clk_i     (clk_i),
                .reset_i   (reset_i),
                .count_i   (s_q.pos[g]),
                .step_i    (res[g].step),
                .bin_enc_i (s_q.cfg[g].bin_encoder),
                .bin_eq_i  (s_q.cfg[g].bin_equiv),
                .scaled_o  (scaled[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Merges write data into a register under the byte enables.
    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [3:0]        be
    );
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // True when the axis may be set rotary.
    function automatic logic rotary_capable(input int axis);
        return axis >= FIRST_ROTARY_AXIS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic [2:0]        axis_sel;
        logic [1:0]        reg_sel;
        logic              hit;
        logic              take;
        logic [DATA_W-1:0] cur;
        logic [DATA_W-1:0] nw;
        logic [POS_W-1:0]  delta;
        logic [CMD_W-1:0]  neg;
        s_d      = s_q;
        axis_sel = address_i[AXIS_SEL_LSB +: 3];
        reg_sel  = address_i[REG_SEL_LSB +: 2];
        hit      = 32'(axis_sel) < AXES;
        take     = (read_i | write_i) & ~s_q.ack;
        cur      = '0;
        nw       = '0;
        delta    = '0;
        neg      = '0;

        // Accept one cycle after the request, drop the acknowledge after.
        s_d.ack = take;

        for (int a = 0; a < AXES; a++) begin
            // Counting: x5 for sine-wave, sign reversed by the direction bit.
            delta = s_q.cfg[a].sine_wave ? POS_W'(SINE_FACTOR)
                                         : POS_W'(PLAIN_FACTOR);
            if (dec_step[a]) begin
                if (dec_up[a] ^ s_q.cfg[a].count_dir) begin
                    s_d.pos[a] = s_q.pos[a] + delta;
                end else begin
                    s_d.pos[a] = s_q.pos[a] - delta;
                end
            end

            // Servo command polarity; the most negative value saturates.
            neg = CMD_W'(-$signed(vel_cmd_i[a]));
            if (vel_cmd_i[a] == {1'b1, {(CMD_W-1){1'b0}}}) begin
                neg = {1'b0, {(CMD_W-1){1'b1}}};
            end
            s_d.drive[a] = s_q.cfg[a].drive_pol ? neg : vel_cmd_i[a];

            // Jog keys swapped by the sense bit.
            s_d.jog_fwd[a] = s_q.cfg[a].jog_sense ? jog_minus_key_i[a]
                                                  : jog_plus_key_i[a];
            s_d.jog_rev[a] = s_q.cfg[a].jog_sense ? jog_plus_key_i[a]
                                                  : jog_minus_key_i[a];
        end

        // Read mux.
        if (take && read_i && hit) begin
            unique case (reg_sel)
                REG_CONFIG: begin
                    s_d.rdata = DATA_W'(s_q.cfg[axis_sel]);
                end
                REG_POSITION: begin
                    s_d.rdata = s_q.pos[axis_sel];
                end
                REG_SCALED: begin
                    s_d.rdata = scaled[axis_sel];
                end
                REG_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[STAT_INCH_BIT]   = s_q.cfg[axis_sel].units_inch;
                    s_d.rdata[STAT_ROTARY_BIT] = s_q.cfg[axis_sel].rotary;
                    s_d.rdata[STAT_VALID_BIT]  = res[axis_sel].valid;
                    s_d.rdata[STAT_PHASE_BIT]  = s_q.phase_err[axis_sel];
                end
            endcase
        end else if (take && read_i) begin
            s_d.rdata = '0;
        end

        // Writes.
        if (take && write_i && hit) begin
            unique case (reg_sel)
                REG_CONFIG: begin
                    cur = DATA_W'(s_q.cfg[axis_sel]);
                    nw  = merge_bytes(cur, writedata_i, byteenable_i);
                    s_d.cfg[axis_sel] = nw[CFG_W-1:0];
                end
                REG_POSITION: begin
                    s_d.pos[axis_sel] = merge_bytes(s_q.pos[axis_sel],
                                                    writedata_i, byteenable_i);
                end
                REG_SCALED: begin
                    s_d.rdata = s_q.rdata;
                end
                REG_STATUS: begin
                    if (byteenable_i[0] && writedata_i[STAT_PHASE_BIT]) begin
                        s_d.phase_err[axis_sel] = 1'b0;
                    end
                end
            endcase
        end

        // Only W and V keep the rotary bit.
        for (int a = 0; a < AXES; a++) begin
            if (!rotary_capable(a)) begin
                s_d.cfg[a].rotary = 1'b0;
            end
            // A double-channel jump is set after any clear so it is not lost.
            if (dec_bad[a]) begin
                s_d.phase_err[a] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
            for (int a = 0; a < AXES; a++) begin
                s_q.cfg[a] <= CFG_RESET;
                s_q.pos[a] <= POS_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign waitrequest_o = (read_i | write_i) & ~s_q.ack;
    assign readdata_o    = s_q.rdata;
    assign drive_cmd_o   = s_q.drive;
    assign jog_fwd_o     = s_q.jog_fwd;
    assign jog_rev_o     = s_q.jog_rev;

endmodule
`default_nettype wire

//--- axis_fb_pkg.sv
// Shared types, register map and scaling constants for the axis feedback block.
package axis_fb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes.
    localparam int NUM_AXES = 5;
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 32;
    localparam int POS_W    = 32;
    localparam int CMD_W    = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: one 16-byte window per axis, axis index in address[6:4].
    localparam logic [ADDR_W-1:0] AXIS_STRIDE  = 7'h10;
    localparam logic [1:0]        REG_CONFIG   = 2'h0;
    localparam logic [1:0]        REG_POSITION = 2'h1;
    localparam logic [1:0]        REG_SCALED   = 2'h2;
    localparam logic [1:0]        REG_STATUS   = 2'h3;
    localparam int                AXIS_SEL_LSB = 4;
    localparam int                REG_SEL_LSB  = 2;

    // Axes from this index upward (W and V) may be set rotary.
    localparam int FIRST_ROTARY_AXIS = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Per-axis configuration word, bit 0 is res_code[0].
    typedef struct packed {
        logic       rotary;        // Bit 13, W and V only.
        logic       bin_equiv;     // Bit 12.
        logic       bin_encoder;   // Bit 11.
        logic       units_inch;    // Bit 10.
        logic       sine_fine;     // Bit 9.
        logic       edge_x2;       // Bit 8.
        logic       sine_wave;     // Bit 7.
        logic       jog_sense;     // Bit 6.
        logic       count_dir;     // Bit 5.
        logic       drive_pol;     // Bit 4.
        logic [3:0] res_code;      // Bits 3:0.
    } axis_cfg_t;

    localparam int        CFG_W     = $bits(axis_cfg_t);
    localparam axis_cfg_t CFG_RESET = 14'h0001;

    // Status word bit positions.
    localparam int STAT_INCH_BIT   = 0;
    localparam int STAT_ROTARY_BIT = 1;
    localparam int STAT_VALID_BIT  = 2;
    localparam int STAT_PHASE_BIT  = 3;

    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Resolution codes and scaling.
    localparam logic [3:0] RES_CODE_1  = 4'h1;
    localparam logic [3:0] RES_CODE_2  = 4'h2;
    localparam logic [3:0] RES_CODE_5  = 4'h5;
    localparam logic [3:0] RES_CODE_10 = 4'hA;

    localparam logic [2:0]  SINE_FACTOR  = 3'h5;
    localparam logic [2:0]  PLAIN_FACTOR = 3'h1;
    localparam logic [10:0] BIN_NUM_EQ0  = 11'd1250;
    localparam logic [10:0] BIN_NUM_EQ1  = 11'd1000;
    localparam int          BIN_SHIFT    = 10;

    typedef struct packed {
        logic a;
        logic b;
    } quad_pins_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] step;
    } res_step_t;

    // Step of one count in base units (um, 0.1 mil or millidegree).
    function automatic res_step_t res_step(input axis_cfg_t c);
        res_step_t r;
        r = '{valid: 1'b0, step: 4'h0};
        if (c.sine_wave && !c.sine_fine) begin
            if (c.res_code == RES_CODE_5) begin
                r = '{valid: 1'b1, step: 4'h1};
            end else if (c.res_code == RES_CODE_10) begin
                r = '{valid: 1'b1, step: 4'h2};
            end
        end else if (c.res_code == RES_CODE_1 || c.res_code == RES_CODE_2 ||
                     c.res_code == RES_CODE_5 || c.res_code == RES_CODE_10) begin
            r = '{valid: 1'b1, step: c.res_code};
        end
        return r;
    endfunction

endpackage

//--- quad_decoder.sv
// Quadrature edge decoder with pin synchronisers and x2 or x4 counting.
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
    input  wire logic                   clk_i,     // System clock.
    input  wire logic                   reset_i,   // Synchronous reset.
    input  wire axis_fb_pkg::quad_pins_t pins_i,   // Feedback channels.
    input  wire logic                   edge_x2_i, // Count channel A only.
    output logic                        step_o,    // One count this cycle.
    output logic                        up_o,      // Direction of the count.
    output logic                        bad_o      // Both channels moved.
);
    import axis_fb_pkg::*;

    typedef struct packed {
        logic [2:0] a_s;
        logic [2:0] b_s;
        logic       a_f;
        logic       b_f;
        logic       step;
        logic       up;
        logic       bad;
    } dec_state_t;

    dec_state_t s_q;
    dec_state_t s_d;

    always_comb begin
        logic na;
        logic nb;
        logic ca;
        logic cb;
        s_d = s_q;
        s_d.a_s = {s_q.a_s[1:0], pins_i.a};
        s_d.b_s = {s_q.b_s[1:0], pins_i.b};
        na = (s_q.a_s[1] == s_q.a_s[2]) ? s_q.a_s[2] : s_q.a_f;
        nb = (s_q.b_s[1] == s_q.b_s[2]) ? s_q.b_s[2] : s_q.b_f;
        ca = na != s_q.a_f;
        cb = nb != s_q.b_f;
        s_d.a_f = na;
        s_d.b_f = nb;
        // Direction follows which channel leads.
        s_d.up   = ca ? (na ^ s_q.b_f) : ~(nb ^ s_q.a_f);
        s_d.step = edge_x2_i ? (ca & ~cb) : (ca ^ cb);
        s_d.bad  = ca & cb;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            // Track the pins through reset so an idle-high channel is no edge.
            s_q     <= '0;
            s_q.a_s <= s_d.a_s;
            s_q.b_s <= s_d.b_s;
            s_q.a_f <= s_q.a_s[2];
            s_q.b_f <= s_q.b_s[2];
        end else begin
            s_q <= s_d;
        end
    end

    assign step_o = s_q.step;
    assign up_o   = s_q.up;
    assign bad_o  = s_q.bad;

endmodule
`default_nettype wire

//--- position_scaler.sv
// Converts a raw count into position units with binary encoder equivalence.
`timescale 1ns/1ps
`default_nettype none
module position_scaler (
    input  wire logic                          clk_i,      // System clock.
    input  wire logic                          reset_i,    // Synchronous reset.
    input  wire logic [axis_fb_pkg::POS_W-1:0] count_i,    // Raw count.
    input  wire logic [3:0]                    step_i,     // Units per count.
    input  wire logic                          bin_enc_i,  // Binary encoder.
    input  wire logic                          bin_eq_i,   // Equivalence.
    output logic      [axis_fb_pkg::POS_W-1:0] scaled_o    // Scaled position.
);
    import axis_fb_pkg::*;

    typedef struct packed {
        logic [POS_W-1:0] scaled;
    } scl_state_t;

    scl_state_t s_q;
    scl_state_t s_d;

    always_comb begin
        logic signed [36:0] base;
        logic signed [48:0] prod;
        logic signed [11:0] num;
        s_d = s_q;
        base = 37'($signed(count_i)) * $signed({1'b0, step_i});
        num  = $signed({1'b0, bin_eq_i ? BIN_NUM_EQ1 : BIN_NUM_EQ0});
        prod = 49'(base) * 49'(num);
        if (bin_enc_i) begin
            s_d.scaled = POS_W'(prod >>> BIN_SHIFT);
        end else begin
            s_d.scaled = POS_W'(base);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign scaled_o = s_q.scaled;

endmodule
`default_nettype wire

//--- axis_feedback_position_counter_props.sv
// Checker for the bus handshake, configuration readback, drive and jog keys.
`timescale 1ns/1ps
`default_nettype none
module axis_feedback_position_counter_props #(
    parameter int AXES = axis_fb_pkg::NUM_AXES // Number of axes.
) (
    input wire logic                  clk_i,           // Clock.
    input wire logic                  reset_i,         // Reset.
    input wire logic [6:0]            address_i,       // Address.
    input wire logic                  read_i,          // Read.
    input wire logic                  write_i,         // Write.
    input wire logic [31:0]           writedata_i,     // Data.
    input wire logic [3:0]            byteenable_i,    // Lanes.
    input wire logic [31:0]           readdata_o,      // Data.
    input wire logic                  waitrequest_o,   // Stall.
    input wire logic [AXES-1:0][15:0] vel_cmd_i,       // Command.
    input wire logic [AXES-1:0][15:0] drive_cmd_o,     // Drive.
    input wire logic [AXES-1:0]       jog_plus_key_i,  // Key +.
    input wire logic [AXES-1:0]       jog_minus_key_i, // Key -.
    input wire logic [AXES-1:0]       jog_fwd_o,       // Move +.
    input wire logic [AXES-1:0]       jog_rev_o        // Move -.
);
    import axis_fb_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////////
    logic [13:0] cfg_q [AXES];
    logic [2:0]  ax;
    logic [1:0]  rg;
    assign ax = address_i[6:4];
    assign rg = address_i[3:2];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int k = 0; k < AXES; k++) cfg_q[k] <= CFG_RESET;
        end else if (write_i && waitrequest_o && ax < AXES && rg == REG_CONFIG) begin
            if (byteenable_i[0]) cfg_q[ax][7:0] <= writedata_i[7:0];
            if (byteenable_i[1]) cfg_q[ax][13:8] <=
                {writedata_i[13] && (int'(ax) >= FIRST_ROTARY_AXIS), writedata_i[12:8]};
        end
    end

    function automatic logic res_ok(input logic [13:0] c);
        if (c[7] && !c[9]) return c[3:0] == 4'h5 || c[3:0] == 4'hA;
        return c[3:0] inside {4'h1, 4'h2, 4'h5, 4'hA};
    endfunction

    function automatic logic [15:0] neg16(input logic [15:0] v);
        return (v == 16'h8000) ? 16'h7FFF : 16'h0000 - v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        (read_i || write_i) && waitrequest_o;
    endsequence
    sequence s_rd_done;
        read_i && !waitrequest_o && ax < AXES;
    endsequence

    AST_WAIT_ONE: assert property (s_take |=> !waitrequest_o)
        else $error("waitrequest late");
    AST_WAIT_IDLE: assert property (!(read_i || write_i) |-> !waitrequest_o)
        else $error("waitrequest idle high");
    AST_CFG_READBACK: assert property (
        s_rd_done ##0 rg == REG_CONFIG |-> readdata_o == {18'h0, cfg_q[ax]})
        else $error("config readback");
    AST_ROT_XYZ: assert property (
        s_rd_done ##0 (rg == REG_CONFIG && ax < FIRST_ROTARY_AXIS) |-> !readdata_o[13])
        else $error("rotary on linear axis");
    AST_STATUS: assert property (
        s_rd_done ##0 rg == REG_STATUS |->
        readdata_o[2:0] == {res_ok(cfg_q[ax]), cfg_q[ax][13], cfg_q[ax][10]})
        else $error("status bits");

    for (genvar k = 0; k < AXES; k++) begin : g_ax
        AST_DRIVE_POL: assert property (!$past(reset_i) |-> drive_cmd_o[k] ==
            ($past(cfg_q[k][4]) ? neg16($past(vel_cmd_i[k])) : $past(vel_cmd_i[k])))
            else $error("drive polarity");
        AST_JOG_FWD: assert property (!$past(reset_i) |-> jog_fwd_o[k] ==
            ($past(cfg_q[k][6]) ? $past(jog_minus_key_i[k]) : $past(jog_plus_key_i[k])))
            else $error("forward jog");
        AST_JOG_REV: assert property (!$past(reset_i) |-> jog_rev_o[k] ==
            ($past(cfg_q[k][6]) ? $past(jog_plus_key_i[k]) : $past(jog_minus_key_i[k])))
            else $error("reverse jog");
    end
endmodule

bind axis_feedback_position_counter axis_feedback_position_counter_props #(
    .AXES(AXES)
) axis_feedback_position_counter_props_i (
    .clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .vel_cmd_i(vel_cmd_i), .drive_cmd_o(drive_cmd_o),
    .jog_plus_key_i(jog_plus_key_i), .jog_minus_key_i(jog_minus_key_i),
    .jog_fwd_o(jog_fwd_o), .jog_rev_o(jog_rev_o)
);
`default_nettype wire

//--- quad_encoder_model.sv
// Incremental encoder model producing quadrature channels for one axis.
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
    input  wire logic                    clk_i,  // Paces the channel edges.
    output var  axis_fb_pkg::quad_pins_t pins_o  // Channel pair.
);
    import axis_fb_pkg::*;

    logic [1:0] phase_q = 2'h0;

    // Phase order 00, 10, 11, 01 has channel A leading B when moving up.
    assign pins_o = '{a: phase_q[1] ^ phase_q[0], b: phase_q[1]};

    // Edges are spaced four cycles apart so the decoder can resolve each one.
    task automatic move(input int edges, input bit up);
        for (int i = 0; i < edges; i++) begin
            repeat (4) @(posedge clk_i);
            phase_q <= up ? phase_q + 2'h1 : phase_q - 2'h1;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the five-axis feedback counter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import axis_fb_pkg::*;

    localparam int N = NUM_AXES;

    logic                    clk;
    logic                    reset;
    logic [ADDR_W-1:0]       address;
    logic                    read;
    logic                    write;
    logic [DATA_W-1:0]       writedata;
    logic [3:0]              byteenable;
    logic [DATA_W-1:0]       readdata;
    logic                    waitrequest;
    quad_pins_t [N-1:0]      quad;
    logic [N-1:0][CMD_W-1:0] vel_cmd;
    logic [N-1:0][CMD_W-1:0] drive_cmd;
    logic [N-1:0]            jog_plus;
    logic [N-1:0]            jog_minus;
    logic [N-1:0]            jog_fwd;
    logic [N-1:0]            jog_rev;
    logic [DATA_W-1:0]       rd;
    int                      err_total = 0;
    int                      n_compared = 0;

    always #4 clk = ~clk;

    axis_feedback_position_counter axis_feedback_position_counter_i (
        .clk_i(clk), .reset_i(reset), .address_i(address), .read_i(read),
        .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
        .readdata_o(readdata), .waitrequest_o(waitrequest), .quad_i(quad),
        .vel_cmd_i(vel_cmd), .drive_cmd_o(drive_cmd),
        .jog_plus_key_i(jog_plus), .jog_minus_key_i(jog_minus),
        .jog_fwd_o(jog_fwd), .jog_rev_o(jog_rev)
    );

    for (genvar g = 0; g < N; g++) begin : g_enc
        quad_encoder_model quad_encoder_model_i (.clk_i(clk), .pins_o(quad[g]));
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low.
    task automatic access(input int ax, input logic [1:0] rg, input logic wr_en,
                          input logic [31:0] wd, input logic [3:0] be);
        @(posedge clk);
        address    <= {3'(ax), rg, 2'b00};
        read       <= !wr_en;
        write      <= wr_en;
        writedata  <= wd;
        byteenable <= be;
        for (int i = 0; i <= 40; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
            if (i == 40) begin
                err_total++;
                conclude();
            end
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input int ax, input logic [1:0] rg, input logic [31:0] wd);
        access(ax, rg, 1'b1, wd, 4'hF);
    endtask

    task automatic rdchk(input int ax, input logic [1:0] rg,
                         input logic [31:0] exp);
        access(ax, rg, 1'b0, 32'h0, 4'hF);
        check($sformatf("axis %0d register %0d", ax, rg), exp, rd);
    endtask

    task automatic mv(input int n, input bit up);
        g_enc[0].quad_encoder_model_i.move(n, up);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {address, read, write, writedata, byteenable} = '0;
        {vel_cmd, jog_plus, jog_minus} = '0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rdchk(0, REG_CONFIG, 32'h1);
        rdchk(0, REG_POSITION, 32'h0);
        wr(5, REG_CONFIG, 32'hFFFF);
        rdchk(5, REG_CONFIG, 32'h0);
        wr(3, REG_CONFIG, 32'h2001);
        rdchk(3, REG_CONFIG, 32'h2001);
        rdchk(3, REG_STATUS, 32'h6);
        wr(0, REG_CONFIG, 32'h2401);
        rdchk(0, REG_CONFIG, 32'h401);
        rdchk(0, REG_STATUS, 32'h5);
        access(2, REG_CONFIG, 1'b1, 32'hFFFF, 4'h1);
        rdchk(2, REG_CONFIG, 32'hFF);
        wr(0, REG_CONFIG, 32'h1);
        mv(8, 1'b1);
        rdchk(0, REG_POSITION, 32'h8);
        wr(0, REG_CONFIG, 32'h31);
        mv(4, 1'b1);
        rdchk(0, REG_POSITION, 32'h4);
        wr(0, REG_CONFIG, 32'h1);
        mv(4, 1'b0);
        rdchk(0, REG_POSITION, 32'h0);
        wr(0, REG_CONFIG, 32'h101);
        mv(8, 1'b1);
        rdchk(0, REG_POSITION, 32'h4);
        wr(0, REG_POSITION, 32'h0);
        wr(0, REG_CONFIG, 32'h81);
        mv(4, 1'b1);
        rdchk(0, REG_POSITION, 32'h14);
        rdchk(0, REG_SCALED, 32'h0);
        rdchk(0, REG_STATUS, 32'h0);
        wr(0, REG_CONFIG, 32'h8A);
        rdchk(0, REG_SCALED, 32'h28);
        wr(0, REG_CONFIG, 32'h28A);
        rdchk(0, REG_SCALED, 32'hC8);
        wr(0, REG_CONFIG, 32'h2);
        rdchk(0, REG_SCALED, 32'h28);
        wr(0, REG_POSITION, 32'h400);
        wr(0, REG_CONFIG, 32'h801);
        rdchk(0, REG_SCALED, 32'h4E2);
        wr(0, REG_CONFIG, 32'h1801);
        rdchk(0, REG_SCALED, 32'h3E8);
        wr(0, REG_CONFIG, 32'h1001);
        rdchk(0, REG_SCALED, 32'h400);
        wr(0, REG_POSITION, 32'hFFFF_FFFB);
        wr(0, REG_CONFIG, 32'h2);
        rdchk(0, REG_SCALED, 32'hFFFF_FFF6);
        for (int k = 0; k < N; k++) begin
            wr(k, REG_CONFIG, 32'h51);
            @(posedge clk);
            vel_cmd[k]  <= 16'h8000;
            jog_plus[k] <= 1'b1;
            repeat (2) @(posedge clk);
            check("drive inverted", 32'h7FFF, 32'(drive_cmd[k]));
            check("jog swapped", 32'h1, {30'h0, jog_fwd[k], jog_rev[k]});
            wr(k, REG_CONFIG, 32'h1);
            @(posedge clk);
            vel_cmd[k]   <= 16'h0123;
            jog_plus[k]  <= 1'b0;
            jog_minus[k] <= 1'b1;
            repeat (2) @(posedge clk);
            check("drive plain", 32'h123, 32'(drive_cmd[k]));
            check("jog plain", 32'h1, {30'h0, jog_fwd[k], jog_rev[k]});
        end
        conclude();
    end
endmodule
`default_nettype wire
